// ==== logic/asu_core.sv ====
// async serial unit: 8N1 transceiver with port 5 handshake and irq
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - link runs at 4800 bit/s both ways
// - frame: start, eight data, one stop
// - port 5 bit0 request out, bit1 in
// - request output active low asks send
// - full receive holding raises serial interrupt
// - servicing received byte drives request high
// - status flags overrun or framing error
// - receive holding read clears error flag
// - good byte read with receive-complete flag
// - start sending only while request in low
// - status bit5 shows transmit holding empty
// - status bit1 set enables transmitter
// - transmit holding write supplies next byte
// - port 5 bit0 direction set to output
// - status then holding read clears full and error flags
module asu_core
  import asu_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire asu_bus_t   bus,
  output logic [7:0]      rdata,
  input  wire logic       rx_line,
  output logic            tx_line,
  input  wire logic       p5_req_in_n,
  output logic            p5_req_out_n,
  output logic            p5_req_out_oe,
  output logic            irq
);
  // divider is 16 bits; below two the tick would be held on
  if (TICK_DIV < 2 || TICK_DIV > 65535) begin : g_div_check
    $error("asu_core: TICK_DIV out of range");
  end

  function automatic logic hit(input asu_bus_t b, input logic [7:0] a);
    return b.addr == a;
  endfunction

  logic [7:0]  rate_mode_r, scs1_r, scs2_r, t3_ctrl_r, t3_period_r;
  logic [7:0]  p5_val_r, p5_dir_r, rx_hold_r, tx_hold_r;
  logic [IRQ_BITS-1:0] irq_stat_r, irq_mask_r;
  logic [15:0] tick_cnt_r;
  logic        tick;
  logic        status_seen_r;

  // oversample tick; 16 per bit gives 4800 bit/s
  // bit rate
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= 16'h0000;
    end else if (clk_en) begin
      if (tick_cnt_r == 16'(TICK_DIV - 1))
        tick_cnt_r <= 16'h0000;
      else
        tick_cnt_r <= tick_cnt_r + 16'h0001;
    end
  end
  assign tick = clk_en && (tick_cnt_r == 16'(TICK_DIV - 1));

  // ---------------- receiver ----------------
  asu_state_t rx_st_r;
  logic [3:0] rx_sub_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic       rx_s1_r, rx_s2_r;
  logic       rx_full_r, rx_err_r;
  logic       rx_done, rx_fault;
  logic       rd_hold;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end else if (clk_en) begin
      rx_s1_r <= rx_line;
      rx_s2_r <= rx_s1_r;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_st_r  <= ASU_IDLE;
      rx_sub_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_sh_r  <= 8'h00;
    end else if (tick) begin
      case (rx_st_r)
        ASU_IDLE: begin
          rx_sub_r <= 4'h0;
          if (!rx_s2_r && scs1_r[SCS1_RX_EN])
            rx_st_r <= ASU_START;
        end
        ASU_START: begin
          rx_sub_r <= rx_sub_r + 4'h1;
          if (rx_sub_r == 4'h7) begin
            rx_sub_r <= 4'h0;
            rx_bit_r <= 3'h0;
            // glitch shorter than half a bit is dropped
            rx_st_r  <= rx_s2_r ? ASU_IDLE : ASU_DATA;
          end
        end
        ASU_DATA: begin
          rx_sub_r <= rx_sub_r + 4'h1;
          if (rx_sub_r == 4'hf) begin
            rx_sh_r  <= {rx_s2_r, rx_sh_r[7:1]};
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == 3'(DATA_BITS - 1))
              rx_st_r <= ASU_STOP;
          end
        end
        ASU_STOP: begin
          rx_sub_r <= rx_sub_r + 4'h1;
          if (rx_sub_r == 4'hf)
            rx_st_r <= ASU_IDLE;
        end
        default: rx_st_r <= ASU_IDLE;
      endcase
    end
  end

  assign rx_done = tick && rx_st_r == ASU_STOP && rx_sub_r == 4'hf;
  // overrun when holding still full, framing when stop bit low
  assign rx_fault = rx_done && (rx_full_r || !rx_s2_r);
  assign rd_hold  = clk_en && bus.rd && hit(bus, ADDR_RX_HOLD);

  // good byte lands in holding register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      rx_hold_r <= 8'h00;
    else if (rx_done && !rx_full_r && rx_s2_r)
      rx_hold_r <= rx_sh_r;
  end

  // status read arms the clear; holding read completes it; set wins
  // two-step clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status_seen_r <= 1'b0;
      rx_full_r     <= 1'b0;
    end else if (clk_en) begin
      if (bus.rd && hit(bus, ADDR_SCS1))
        status_seen_r <= rx_full_r | rx_err_r;
      else if (rd_hold)
        status_seen_r <= 1'b0;
      if (rx_done && !rx_fault)
        rx_full_r <= 1'b1;
      else if (rd_hold && status_seen_r)
        rx_full_r <= 1'b0;
    end
  end

  // error flag; dummy read clears it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      rx_err_r <= 1'b0;
    else if (clk_en) begin
      if (rx_fault)
        rx_err_r <= 1'b1;
      else if (rd_hold && status_seen_r)
        rx_err_r <= 1'b0;
    end
  end

  // ---------------- transmitter ----------------
  asu_state_t tx_st_r;
  logic [3:0] tx_sub_r;
  logic [2:0] tx_bit_r;
  logic [7:0] tx_sh_r;
  logic       tx_empty_r, tx_out_r, cts_s_r;
  logic       tx_load, wr_tx;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      cts_s_r <= 1'b1;
    else if (clk_en)
      cts_s_r <= p5_req_in_n;
  end

  // hold off while partner request is high
  assign tx_load = tick && tx_st_r == ASU_IDLE && !tx_empty_r &&
                   scs1_r[SCS1_TX_EN] && !cts_s_r;
  assign wr_tx   = clk_en && bus.wr && hit(bus, ADDR_TX_HOLD);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      tx_hold_r <= 8'h00;
    else if (wr_tx)
      tx_hold_r <= bus.wdata;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      tx_empty_r <= 1'b1;
    else if (wr_tx)
      tx_empty_r <= 1'b0;
    else if (tx_load)
      tx_empty_r <= 1'b1;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_st_r  <= ASU_IDLE;
      tx_sub_r <= 4'h0;
      tx_bit_r <= 3'h0;
      tx_sh_r  <= 8'h00;
      tx_out_r <= 1'b1;
    end else if (tick) begin
      case (tx_st_r)
        ASU_IDLE: begin
          tx_out_r <= 1'b1;
          tx_sub_r <= 4'h0;
          if (tx_load) begin
            tx_sh_r  <= tx_hold_r;
            tx_out_r <= 1'b0;
            tx_st_r  <= ASU_START;
          end
        end
        ASU_START: begin
          tx_sub_r <= tx_sub_r + 4'h1;
          if (tx_sub_r == 4'hf) begin
            tx_out_r <= tx_sh_r[0];
            tx_bit_r <= 3'h0;
            tx_st_r  <= ASU_DATA;
          end
        end
        ASU_DATA: begin
          tx_sub_r <= tx_sub_r + 4'h1;
          if (tx_sub_r == 4'hf) begin
            tx_bit_r <= tx_bit_r + 3'h1;
            tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
            if (tx_bit_r == 3'(DATA_BITS - 1)) begin
              tx_out_r <= 1'b1;
              tx_st_r  <= ASU_STOP;
            end else
              tx_out_r <= tx_sh_r[1];
          end
        end
        ASU_STOP: begin
          tx_sub_r <= tx_sub_r + 4'h1;
          if (tx_sub_r == 4'hf)
            tx_st_r <= ASU_IDLE;
        end
        default: tx_st_r <= ASU_IDLE;
      endcase
    end
  end
  assign tx_line = tx_out_r;

  // ---------------- registers ----------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rate_mode_r <= RST_ZERO;
      scs2_r      <= RST_ZERO;
      t3_ctrl_r   <= RST_ZERO;
      t3_period_r <= RST_PERIOD;
      scs1_r      <= RST_SCS1;
    end else if (clk_en && bus.wr) begin
      if (hit(bus, ADDR_RATE_MODE)) rate_mode_r <= bus.wdata;
      if (hit(bus, ADDR_SCS2))      scs2_r      <= bus.wdata;
      if (hit(bus, ADDR_T3_CTRL))   t3_ctrl_r   <= bus.wdata;
      if (hit(bus, ADDR_T3_PERIOD)) t3_period_r <= bus.wdata;
      if (hit(bus, ADDR_SCS1))      scs1_r      <= bus.wdata;
    end
  end

  // software sets bit0 high when servicing a byte
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      p5_val_r <= RST_P5_VAL;
      p5_dir_r <= RST_ZERO;
    end else if (clk_en && bus.wr) begin
      if (hit(bus, ADDR_P5_VALUE)) p5_val_r <= bus.wdata;
      if (hit(bus, ADDR_P5_DIR))   p5_dir_r <= bus.wdata;
    end
  end

  // active low request, driven only when direction is output
  assign p5_req_out_n  = p5_val_r[P5_RTS_OUT];
  assign p5_req_out_oe = p5_dir_r[P5_RTS_OUT];

  // sticky events, write one to clear; set wins
  logic [IRQ_BITS-1:0] ev;
  assign ev = {tx_load, rx_fault, rx_done && !rx_fault};
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else if (clk_en) begin
      if (bus.wr && hit(bus, ADDR_IRQ_MASK))
        irq_mask_r <= bus.wdata[IRQ_BITS-1:0];
      if (bus.wr && hit(bus, ADDR_IRQ_STAT))
        irq_stat_r <= (irq_stat_r & ~bus.wdata[IRQ_BITS-1:0]) | ev;
      else
        irq_stat_r <= irq_stat_r | ev;
    end
  end

  // serial interrupt: full holding or error with rx irq enable, empty transmit holding with tx irq enable, or masked status
  assign irq = |(irq_stat_r & irq_mask_r) ||
               (scs1_r[SCS1_RX_IE] && (rx_full_r || rx_err_r)) ||
               (scs1_r[SCS1_TX_IE] && tx_empty_r);

  // read data one cycle after strobe; unmapped reads zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      rdata <= 8'h00;
    else if (clk_en) begin
      rdata <= 8'h00;
      if (bus.rd) begin
        case (bus.addr)
          ADDR_RATE_MODE: rdata <= rate_mode_r;
          // bit5 is the transmit empty flag
          ADDR_SCS1: rdata <= {rx_full_r, rx_err_r, tx_empty_r,
                               scs1_r[4:0]};
          ADDR_RX_HOLD:   rdata <= rx_hold_r;
          ADDR_P5_VALUE:  rdata <= {6'h00, p5_req_in_n,
                                    p5_val_r[P5_RTS_OUT]};
          ADDR_T3_CTRL:   rdata <= t3_ctrl_r;
          ADDR_T3_PERIOD: rdata <= t3_period_r;
          ADDR_SCS2:      rdata <= scs2_r;
          ADDR_IRQ_STAT:  rdata <= {5'h00, irq_stat_r};
          ADDR_IRQ_MASK:  rdata <= {5'h00, irq_mask_r};
          default:        rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== logic/asu_pkg.sv ====
// package for the async serial unit with flow handshake
package asu_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] ADDR_RATE_MODE = 8'h10;
  localparam logic [7:0] ADDR_SCS1      = 8'h11;
  localparam logic [7:0] ADDR_RX_HOLD   = 8'h12;
  localparam logic [7:0] ADDR_TX_HOLD   = 8'h13;
  localparam logic [7:0] ADDR_P5_VALUE  = 8'h15;
  localparam logic [7:0] ADDR_T3_CTRL   = 8'h1b;
  localparam logic [7:0] ADDR_T3_PERIOD = 8'h1c;
  localparam logic [7:0] ADDR_SCS2      = 8'h1e;
  localparam logic [7:0] ADDR_P5_DIR    = 8'h20;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h24;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h25;
  // serial_control_status_1 fields
  localparam int SCS1_WAKE_EN  = 0;
  localparam int SCS1_TX_EN    = 1;
  localparam int SCS1_TX_IE    = 2;
  localparam int SCS1_RX_EN    = 3;
  localparam int SCS1_RX_IE    = 4;
  localparam int SCS1_TX_EMPTY = 5;
  localparam int SCS1_ERR      = 6;
  localparam int SCS1_RX_FULL  = 7;
  // port 5 bits
  localparam int P5_RTS_OUT = 0;
  localparam int P5_CTS_IN  = 1;
  // interrupt status bits
  localparam int IRQ_RX_DONE = 0;
  localparam int IRQ_RX_ERR  = 1;
  localparam int IRQ_TX_EMPTY = 2;
  localparam int IRQ_BITS    = 3;
  // reset values
  localparam logic [7:0] RST_SCS1   = 8'h20;
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] RST_P5_VAL = 8'h01;
  localparam logic [7:0] RST_PERIOD = 8'h07;
  // timing: 4800 bit/s at 100 MHz, 16 samples per bit
  localparam int CLK_HZ       = 100_000_000;
  localparam int BAUD         = 4800;
  localparam int OVERSAMPLE   = 16;
  localparam int TICK_CYCLES  = CLK_HZ / (BAUD * OVERSAMPLE);
  localparam int DATA_BITS    = 8;

  typedef enum logic [1:0] {
    ASU_IDLE  = 2'b00,
    ASU_START = 2'b01,
    ASU_DATA  = 2'b10,
    ASU_STOP  = 2'b11
  } asu_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } asu_bus_t;
endpackage

// ==== test/asu_core_asserts.sv ====
// assertion checker on the async serial core ports
`timescale 1ns/100ps
`default_nettype none
module asu_core_asserts
  import asu_pkg::*;
#(
  parameter int TICK_DIV = 4
) (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       clk_en,
  input wire asu_bus_t   bus,
  input wire logic [7:0] rdata,
  input wire logic       rx_line,
  input wire logic       tx_line,
  input wire logic       p5_req_in_n,
  input wire logic       p5_req_out_n,
  input wire logic       p5_req_out_oe,
  input wire logic       irq
);
  localparam int BITC = 16 * TICK_DIV;
  int fc;
  int lo_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // frame position, zero between frames
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) fc <= 0;
    else if (fc != 0) fc <= fc - 1;
    else if ($fell(tx_line)) fc <= 10 * BITC - 1;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) lo_cnt <= 0;
    else lo_cnt <= tx_line ? 0 : lo_cnt + 1;
  end
  rd_idle_a: assert property (
    $past(clk_en) && !$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read");
  p5_read_a: assert property (
    $past(clk_en && bus.rd && bus.addr == ADDR_P5_VALUE)
    |-> rdata[1] == $past(p5_req_in_n))
    else $error("port read misses partner request");
  oe_cause_a: assert property (
    $changed(p5_req_out_oe)
    |-> $past(clk_en && bus.wr && bus.addr == ADDR_P5_DIR))
    else $error("pin enable moved without write");
  rts_cause_a: assert property (
    $changed(p5_req_out_n)
    |-> $past(clk_en && bus.wr && bus.addr == ADDR_P5_VALUE))
    else $error("request moved without write");
  rts_value_a: assert property (
    $past(clk_en && bus.wr && bus.addr == ADDR_P5_VALUE)
    |-> p5_req_out_n == $past(bus.wdata[0]))
    else $error("request pin differs from written bit");
  start_bit_a: assert property (fc > 9 * BITC |-> !tx_line)
    else $error("start bit too short");
  stop_bit_a: assert property (fc != 0 && fc <= BITC |-> tx_line)
    else $error("stop bit not high");
  bit_len_a: assert property ($rose(tx_line) |-> lo_cnt % BITC == 0)
    else $error("low run not whole bits");
  // request pin passes one flop before the load tick
  tx_gate_a: assert property (
    $fell(tx_line) && fc == 0 |-> !$past(p5_req_in_n, 2))
    else $error("frame started while partner not ready");
endmodule
bind asu_core asu_core_asserts #(.TICK_DIV(TICK_DIV)) asu_core_asserts_inst (
  .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .bus(bus), .rdata(rdata),
  .rx_line(rx_line), .tx_line(tx_line), .p5_req_in_n(p5_req_in_n),
  .p5_req_out_n(p5_req_out_n), .p5_req_out_oe(p5_req_out_oe), .irq(irq));
`default_nettype wire

// ==== test/asu_term_model.sv ====
// terminal model: serial peer with request handshake
`timescale 1ns/100ps
`default_nettype none
module asu_term_model #(
  parameter int TICK_DIV = 4
) (
  input  wire logic      clk_sys,
  input  wire logic      ready,
  input  wire logic      tx_line,
  input  wire logic      p5_req_out_n,
  output var logic       rx_line,
  output logic           p5_req_in_n,
  output var logic [7:0] got_byte,
  output var logic [7:0] got_cnt
);
  localparam int BITC = 16 * TICK_DIV;
  logic [7:0] sh;
  assign p5_req_in_n = !ready;
  initial begin
    rx_line = 1'b1;
    got_byte = 8'h00;
    got_cnt = 8'h00;
  end
  always begin
    @(negedge tx_line);
    repeat (BITC / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (BITC) @(posedge clk_sys);
      sh[i] = tx_line;
    end
    repeat (BITC) @(posedge clk_sys);
    got_byte = sh;
    got_cnt = got_cnt + 8'h01;
  end
  task automatic send(input logic [7:0] d, input logic bad);
    logic [10:0] fr;
    int n;
    // trailing idle bit restores the line after a bad stop
    fr = {1'b1, ~bad, d, 1'b0};
    n = 0;
    while (p5_req_out_n && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    for (int b = 0; b < 11; b++) begin
      @(posedge clk_sys);
      rx_line <= fr[b];
      repeat (BITC - 1) @(posedge clk_sys);
    end
    // leave the edge so callers see settled outputs
    #1;
  endtask
endmodule
`default_nettype wire

// ==== test/test_async_serial_with_flow_handshake.sv ====
// testbench for the async serial core with flow handshake
`timescale 1ns/100ps
`default_nettype none
module test_async_serial_with_flow_handshake
  import asu_pkg::*;
;
  localparam int TD = 4;
  localparam int FRAME = 160 * TD;
  logic       clk_sys;
  logic       rst;
  logic       clk_en;
  asu_bus_t   bus;
  logic [7:0] rdata;
  logic       rx_line;
  logic       tx_line;
  logic       p5_req_in_n;
  logic       p5_req_out_n;
  logic       p5_req_out_oe;
  logic       irq;
  logic       ready;
  logic [7:0] got_byte;
  logic [7:0] got_cnt;
  int         failures;
  int         comparisons;
  asu_core #(.TICK_DIV(TD)) asu_core_inst (
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .bus(bus), .rdata(rdata),
    .rx_line(rx_line), .tx_line(tx_line), .p5_req_in_n(p5_req_in_n),
    .p5_req_out_n(p5_req_out_n), .p5_req_out_oe(p5_req_out_oe), .irq(irq));
  asu_term_model #(.TICK_DIV(TD)) asu_term_model_inst (
    .clk_sys(clk_sys), .ready(ready), .tx_line(tx_line),
    .p5_req_out_n(p5_req_out_n), .rx_line(rx_line),
    .p5_req_in_n(p5_req_in_n), .got_byte(got_byte), .got_cnt(got_cnt));
  always #5 clk_sys = ~clk_sys;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    bus <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    bus <= '0;
    #1 chk(rdata, exp);
  endtask
  task automatic set_ready(input logic v);
    @(posedge clk_sys);
    ready <= v;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20 * FRAME) @(posedge clk_sys);
    failures++;
    tally_and_finish();
  end
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    clk_en = 1'b1;
    bus = '0;
    ready = 1'b0;
    failures = 0;
    comparisons = 0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADDR_SCS1, 8'h20);
    rd(ADDR_P5_VALUE, 8'h03);
    rd(ADDR_T3_PERIOD, 8'h07);
    rd(8'h14, 8'h00);
    wr(ADDR_RATE_MODE, 8'h24);
    rd(ADDR_RATE_MODE, 8'h24);
    chk({7'h00, p5_req_out_oe}, 8'h00);
    wr(ADDR_P5_DIR, 8'h01);
    chk({7'h00, p5_req_out_oe}, 8'h01);
    wr(ADDR_P5_VALUE, 8'h00);
    chk({7'h00, p5_req_out_n}, 8'h00);
    rd(ADDR_P5_VALUE, 8'h02);
    $display("test done: reset and port");
    wr(ADDR_SCS1, 8'h08);
    wr(ADDR_IRQ_MASK, 8'h00);
    asu_term_model_inst.send(8'ha5, 1'b0);
    chk({7'h00, irq}, 8'h00);
    rd(ADDR_IRQ_STAT, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h01);
    chk({7'h00, irq}, 8'h01);
    wr(ADDR_IRQ_STAT, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wr(ADDR_SCS1, 8'h18);
    chk({7'h00, irq}, 8'h01);
    rd(ADDR_SCS1, 8'hb8);
    rd(ADDR_RX_HOLD, 8'ha5);
    chk({7'h00, irq}, 8'h00);
    wr(ADDR_P5_VALUE, 8'h01);
    chk({7'h00, p5_req_out_n}, 8'h01);
    // a write while the clock enable is low must be lost
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(ADDR_P5_VALUE, 8'h00);
    chk({7'h00, p5_req_out_n}, 8'h01);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    $display("test done: receive");
    wr(ADDR_P5_VALUE, 8'h00);
    asu_term_model_inst.send(8'h3c, 1'b1);
    rd(ADDR_SCS1, 8'h78);
    rd(ADDR_IRQ_STAT, 8'h02);
    rd(ADDR_RX_HOLD, 8'ha5);
    rd(ADDR_SCS1, 8'h38);
    asu_term_model_inst.send(8'h81, 1'b0);
    asu_term_model_inst.send(8'h7e, 1'b0);
    rd(ADDR_SCS1, 8'hf8);
    rd(ADDR_RX_HOLD, 8'h81);
    rd(ADDR_SCS1, 8'h38);
    wr(ADDR_IRQ_STAT, 8'hff);
    $display("test done: errors");
    set_ready(1'b1);
    wr(ADDR_TX_HOLD, 8'h5a);
    rd(ADDR_SCS1, 8'h18);
    repeat (FRAME) @(posedge clk_sys);
    chk(got_cnt, 8'h00);
    set_ready(1'b0);
    wr(ADDR_SCS1, 8'h1a);
    repeat (FRAME) @(posedge clk_sys);
    chk(got_cnt, 8'h00);
    set_ready(1'b1);
    repeat (FRAME + 64) @(posedge clk_sys);
    chk(got_cnt, 8'h01);
    chk(got_byte, 8'h5a);
    rd(ADDR_SCS1, 8'h3a);
    rd(ADDR_IRQ_STAT, 8'h04);
    wr(ADDR_SCS1, 8'h1e);
    chk({7'h00, irq}, 8'h01);
    wr(ADDR_SCS1, 8'h1a);
    chk({7'h00, irq}, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h04);
    chk({7'h00, irq}, 8'h01);
    $display("test done: transmit");
    tally_and_finish();
  end
endmodule
`default_nettype wire
